// File: logic/hpms_pkg.sv
// Operation
// - port-select high picks the two-wire host bus, low picks four-wire serial
// - in four-wire mode address-zero pin is active-low chip select from host
// - in two-wire mode bus address comes from the two address-select pins
// - in four-wire mode address-one pin is serial data in from host
// - infrared strap sampled at power-up: high plain coding, low infrared
// - half-duplex strap low makes request-to-send the RS-485 direction output
// - unconnected straps read high: plain coding, no automatic direction
// - interrupt is one open-drain output pulled low while asserted
// - reset low over 40 ns returns registers and outputs to reset state
// - in reset transmitters stay idle and receiver inputs are ignored
// - clear-to-send serves automatic transmit flow control or general input
// - request-to-send selects receive flow, RS-485 direction or software output
// - modem pins double as general pins, by function bit and direction bits
// - transmit rests high in plain mode and in reset, low in infrared
// - direction output high while receiving, low while transmitting
package hpms_pkg;

	// ==========================================================
	// timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int RESET_MIN_NS = 40;
	localparam int RESET_MIN_CYC_RAW = (RESET_MIN_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int RESET_MIN_CYC = (RESET_MIN_CYC_RAW < 1) ? 1
		: RESET_MIN_CYC_RAW;
	localparam int SYNC_STAGES = 2;
	localparam int STRAP_SETTLE_CYC = SYNC_STAGES + RESET_MIN_CYC;
	localparam int SETTLE_CNT_W = 4;

	// ==========================================================
	// widths and field positions
	localparam int CHANNELS = 2;
	localparam int BYTE_W = 8;
	localparam int BIT_CNT_W = 3;
	localparam int GPIO_W = 8;
	localparam int BUS_ADDR_W = 7;
	localparam int PIN_FUNC_MODEM_BIT = 1;
	localparam int GP_SET_READY_CH1 = 0;
	localparam int GP_TERMINAL_READY_CH1 = 1;
	localparam int GP_SET_READY_CH0 = 4;
	localparam int GP_TERMINAL_READY_CH0 = 5;
	localparam int GP_CARRIER_DETECT_CH0 = 6;
	localparam int GP_RING_INDICATE_CH0 = 7;
	localparam logic [GPIO_W-1:0] MODEM_OUT_MASK =
		GPIO_W'(1 << GP_TERMINAL_READY_CH0) |
		GPIO_W'(1 << GP_TERMINAL_READY_CH1);

	// ==========================================================
	// bus address layout and levels
	localparam logic [BUS_ADDR_W-1:0] BUS_ADDR_BASE = 7'h30;
	localparam int BUS_ADDR_A1_BIT = 2;
	localparam int BUS_ADDR_A0_BIT = 0;
	localparam logic STRAP_DEFAULT = 1'b1;
	localparam logic TX_IDLE_PLAIN = 1'b1;
	localparam logic TX_IDLE_IR = 1'b0;
	localparam logic RX_IDLE_PLAIN = 1'b1;
	localparam logic RX_IDLE_IR = 1'b0;
	localparam logic DIR_RECEIVE_LEVEL = 1'b1;
	localparam logic RTS_RESET_LEVEL = 1'b1;
	localparam logic IRQ_DRIVE_LEVEL = 1'b0;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic two_wire;
		logic infrared;
		logic auto_dir;
	} hpms_mode_t;

	localparam hpms_mode_t MODE_RESET = '{two_wire: 1'b1,
		infrared: 1'b0, auto_dir: 1'b0};

	typedef struct packed {
		logic tx_data;
		logic tx_ir;
		logic tx_busy;
		logic rts_flow_en;
		logic rts_flow_level;
		logic rts_gp_level;
		logic dir_enable;
		logic dir_invert;
		logic cts_flow_en;
	} hpms_chan_ctl_t;

	typedef enum logic [1:0] {ST_SETTLE, ST_RUN} hpms_boot_t;

endpackage : hpms_pkg

// File: logic/hpms_sync2.sv
`timescale 1ns/1ps
// ==========================================================
// two-stage synchroniser, first stage read only by the second
module hpms_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic [WIDTH-1:0] d_in,
	output logic [WIDTH-1:0] q_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] stable_reg;

	// reset values are constants only
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_reg <= RESET_VAL;
			stable_reg <= RESET_VAL;
		end else begin
			meta_reg <= d_in;
			stable_reg <= meta_reg;
		end
	end

	assign q_out = stable_reg;

endmodule : hpms_sync2

// File: logic/hpms_host_port_strap.sv
`timescale 1ns/1ps
module hpms_host_port_strap (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic host_clk_in,
	input wire logic port_select_in,
	input wire logic addr0_or_chip_select_n_in,
	input wire logic addr1_or_serial_in_in,
	input wire logic infrared_strap_n_in,
	input wire logic half_duplex_strap_n_in,
	input wire logic irq_request_in,
	input wire hpms_pkg::hpms_chan_ctl_t [hpms_pkg::CHANNELS-1:0] chan_ctl_in,
	input wire logic [hpms_pkg::CHANNELS-1:0] uart_rx_pin_in,
	input wire logic clear_to_send_ch0_n_in,
	input wire logic clear_to_send_ch1_n_in,
	input wire logic [hpms_pkg::GPIO_W-1:0] gpio_pin_in,
	input wire logic [hpms_pkg::GPIO_W-1:0] pin_function_control_in,
	input wire logic [hpms_pkg::GPIO_W-1:0] pin_direction_control_in,
	input wire logic [hpms_pkg::GPIO_W-1:0] gpio_sw_level_in,
	input wire logic [hpms_pkg::GPIO_W-1:0] modem_out_level_in,
	output hpms_pkg::hpms_mode_t mode_out,
	output logic strap_valid_out,
	output logic [hpms_pkg::BUS_ADDR_W-1:0] bus_address_out,
	output logic chip_selected_out,
	output logic [hpms_pkg::BYTE_W-1:0] host_byte_out,
	output logic host_byte_valid_out,
	output logic irq_n_out,
	output logic irq_oe_out,
	output logic [hpms_pkg::CHANNELS-1:0] uart_tx_out,
	output logic [hpms_pkg::CHANNELS-1:0] uart_rx_core_out,
	output logic request_to_send_ch0_n_out,
	output logic request_to_send_ch1_n_out,
	output logic [hpms_pkg::CHANNELS-1:0] cts_level_out,
	output logic [hpms_pkg::CHANNELS-1:0] cts_hold_tx_out,
	output logic [hpms_pkg::GPIO_W-1:0] gpio_out,
	output logic [hpms_pkg::GPIO_W-1:0] gpio_oe_out,
	output logic [hpms_pkg::GPIO_W-1:0] gpio_read_out
);

	localparam int PIN_W = 5 + 2 * hpms_pkg::CHANNELS + hpms_pkg::GPIO_W;
	localparam logic [PIN_W-1:0] PIN_RESET = '1;
	localparam logic [hpms_pkg::SETTLE_CNT_W-1:0] SETTLE_LAST =
		hpms_pkg::SETTLE_CNT_W'(hpms_pkg::STRAP_SETTLE_CYC - 1);
	localparam logic [hpms_pkg::BIT_CNT_W-1:0] BIT_LAST = '1;

	// ==========================================================
	// pin synchronisers into the system clock
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_sync;
	logic port_select_sync;
	logic addr0_sync;
	logic addr1_sync;
	logic ir_strap_sync;
	logic hd_strap_sync;
	logic [hpms_pkg::CHANNELS-1:0] rx_sync;
	logic [hpms_pkg::CHANNELS-1:0] cts_n_sync;
	logic [hpms_pkg::GPIO_W-1:0] gpio_sync;

	// straps reset to the pulled-up level so an open pin reads high
	assign pin_raw = {port_select_in, addr0_or_chip_select_n_in,
		addr1_or_serial_in_in, infrared_strap_n_in, half_duplex_strap_n_in,
		uart_rx_pin_in, clear_to_send_ch1_n_in, clear_to_send_ch0_n_in,
		gpio_pin_in};
	assign {port_select_sync, addr0_sync, addr1_sync, ir_strap_sync,
		hd_strap_sync, rx_sync, cts_n_sync, gpio_sync} = pin_sync;

	hpms_sync2 #(.WIDTH(PIN_W), .RESET_VAL(PIN_RESET)) u_pin_sync (
		.clk_in(clk_in), .rstn_in(rstn_in),
		.d_in(pin_raw), .q_out(pin_sync));

	// ==========================================================
	// boot sequence: settle, then capture straps once
	hpms_pkg::hpms_boot_t state_reg;
	hpms_pkg::hpms_boot_t state_next;
	logic [hpms_pkg::SETTLE_CNT_W-1:0] settle_cnt_reg;
	logic [hpms_pkg::SETTLE_CNT_W-1:0] settle_cnt_next;
	logic settle_done;
	logic run;

	// wait covers the synchroniser depth so straps seen are real
	assign settle_done = (settle_cnt_reg == SETTLE_LAST);
	assign run = (state_reg == hpms_pkg::ST_RUN);

	always_comb begin
		state_next = state_reg;
		settle_cnt_next = settle_cnt_reg;
		case (state_reg)
			hpms_pkg::ST_SETTLE: begin
				settle_cnt_next = settle_cnt_reg +
					hpms_pkg::SETTLE_CNT_W'(1);
				if (settle_done) begin
					state_next = hpms_pkg::ST_RUN;
				end
			end
			hpms_pkg::ST_RUN: state_next = hpms_pkg::ST_RUN;
			default: state_next = hpms_pkg::ST_SETTLE;
		endcase
	end

	// async reset acts without a clock, so any pulse over 40 ns holds
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_reg <= hpms_pkg::ST_SETTLE;
			settle_cnt_reg <= '0;
		end else begin
			state_reg <= state_next;
			settle_cnt_reg <= settle_cnt_next;
		end
	end

	// ==========================================================
	// mode register
	hpms_pkg::hpms_mode_t mode_reg;
	hpms_pkg::hpms_mode_t mode_next;
	logic capture;

	assign capture = (state_reg == hpms_pkg::ST_SETTLE) && settle_done;

	// port select follows its pin; straps are frozen after capture
	always_comb begin
		mode_next = mode_reg;
		if (capture || run) begin
			mode_next.two_wire = port_select_sync;
		end
		if (capture) begin
			mode_next.infrared = ~ir_strap_sync;
			mode_next.auto_dir = ~hd_strap_sync;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			mode_reg <= hpms_pkg::MODE_RESET;
		end else begin
			mode_reg <= mode_next;
		end
	end
	assign mode_out = mode_reg;
	assign strap_valid_out = run;

	// ==========================================================
	// host address pins and chip select
	logic [hpms_pkg::BUS_ADDR_W-1:0] bus_address_reg;
	logic [hpms_pkg::BUS_ADDR_W-1:0] bus_address_next;
	logic chip_selected_reg;
	logic chip_selected_next;

	// a pin tied low sets its address bit; braces keep the invert 1 bit
	assign bus_address_next = hpms_pkg::BUS_ADDR_BASE |
		(hpms_pkg::BUS_ADDR_W'({~addr1_sync}) << hpms_pkg::BUS_ADDR_A1_BIT) |
		(hpms_pkg::BUS_ADDR_W'({~addr0_sync}) << hpms_pkg::BUS_ADDR_A0_BIT);
	assign chip_selected_next = run && !mode_reg.two_wire &&
		!addr0_sync;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bus_address_reg <= hpms_pkg::BUS_ADDR_BASE;
			chip_selected_reg <= 1'b0;
		end else begin
			if (run && mode_reg.two_wire) begin
				bus_address_reg <= bus_address_next;
			end
			chip_selected_reg <= chip_selected_next;
		end
	end
	assign bus_address_out = bus_address_reg;
	assign chip_selected_out = chip_selected_reg;

	// ==========================================================
	// link domain: serial shift on the host clock
	logic link_clear_n;
	logic [hpms_pkg::BIT_CNT_W-1:0] bit_cnt_reg;
	logic [hpms_pkg::BYTE_W-1:0] shift_reg;
	logic [hpms_pkg::BYTE_W-1:0] shift_next;
	logic [hpms_pkg::BYTE_W-1:0] hold_reg;
	logic req_tgl_reg;
	logic ack_tgl_reg;
	logic ack_tgl_link;
	logic byte_done;
	logic hold_free;

	// chip select high or two-wire mode clears the frame at once; the
	// host clock may stop between frames so nothing waits for an edge
	assign link_clear_n = rstn_in & ~addr0_or_chip_select_n_in &
		~port_select_in;
	assign shift_next = {shift_reg[hpms_pkg::BYTE_W-2:0],
		addr1_or_serial_in_in};
	assign byte_done = (bit_cnt_reg == BIT_LAST);
	assign hold_free = (req_tgl_reg == ack_tgl_link);

	// rising edge sampling relies on the clock idling low here
	always_ff @(posedge host_clk_in or negedge link_clear_n) begin
		if (!link_clear_n) begin
			bit_cnt_reg <= '0;
			shift_reg <= '0;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + hpms_pkg::BIT_CNT_W'(1);
			shift_reg <= shift_next;
		end
	end

	// a byte arriving before the last one was taken is dropped
	always_ff @(posedge host_clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hold_reg <= '0;
			req_tgl_reg <= 1'b0;
		end else if (byte_done && hold_free && link_clear_n) begin
			hold_reg <= shift_next;
			req_tgl_reg <= ~req_tgl_reg;
		end
	end

	hpms_sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_ack_sync (
		.clk_in(host_clk_in), .rstn_in(rstn_in),
		.d_in(ack_tgl_reg), .q_out(ack_tgl_link));

	// ==========================================================
	// core side of the byte handshake
	logic req_tgl_core;
	logic take_byte;
	logic [hpms_pkg::BYTE_W-1:0] host_byte_reg;
	logic host_byte_valid_reg;

	hpms_sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_req_sync (
		.clk_in(clk_in), .rstn_in(rstn_in),
		.d_in(req_tgl_reg), .q_out(req_tgl_core));

	// hold_reg is stable while the toggles differ, so reading it is safe
	assign take_byte = (req_tgl_core != ack_tgl_reg);

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ack_tgl_reg <= 1'b0;
			host_byte_reg <= '0;
			host_byte_valid_reg <= 1'b0;
		end else begin
			host_byte_valid_reg <= take_byte;
			if (take_byte) begin
				ack_tgl_reg <= req_tgl_core;
				host_byte_reg <= hold_reg;
			end
		end
	end
	assign host_byte_out = host_byte_reg;
	assign host_byte_valid_out = host_byte_valid_reg;

	// ==========================================================
	// interrupt pin: open drain, only ever driven low
	logic irq_oe_reg;
	logic irq_n_reg;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			irq_oe_reg <= 1'b0;
			irq_n_reg <= hpms_pkg::IRQ_DRIVE_LEVEL;
		end else begin
			irq_oe_reg <= run && irq_request_in;
			irq_n_reg <= hpms_pkg::IRQ_DRIVE_LEVEL;
		end
	end

	assign irq_oe_out = irq_oe_reg;
	assign irq_n_out = irq_n_reg;

	// ==========================================================
	// per-channel transmit, receive and flow pins
	logic [hpms_pkg::CHANNELS-1:0] rts_n_vec;

	generate
		for (genvar ch = 0; ch < hpms_pkg::CHANNELS; ch++) begin : g_chan
			logic tx_reg;
			logic tx_next;
			logic rx_reg;
			logic rx_next;
			logic rts_n_reg;
			logic rts_n_next;
			logic dir_level;
			logic auto_dir;
			logic cts_level_reg;
			logic cts_hold_reg;
			logic tx_idle;
			logic rx_idle;

			assign tx_idle = mode_reg.infrared ? hpms_pkg::TX_IDLE_IR
				: hpms_pkg::TX_IDLE_PLAIN;
			assign rx_idle = mode_reg.infrared ? hpms_pkg::RX_IDLE_IR
				: hpms_pkg::RX_IDLE_PLAIN;
			assign tx_next = !run ? tx_idle : mode_reg.infrared ?
				chan_ctl_in[ch].tx_ir : chan_ctl_in[ch].tx_data;
			assign rx_next = run ? rx_sync[ch] : rx_idle;
			// receive level unless a byte is on the line
			assign dir_level = (chan_ctl_in[ch].tx_busy ?
				~hpms_pkg::DIR_RECEIVE_LEVEL : hpms_pkg::DIR_RECEIVE_LEVEL) ^
				chan_ctl_in[ch].dir_invert;
			assign auto_dir = mode_reg.auto_dir | chan_ctl_in[ch].dir_enable;
			// direction wins over flow, flow over software level
			assign rts_n_next = !run ? hpms_pkg::RTS_RESET_LEVEL :
				auto_dir ? dir_level :
				chan_ctl_in[ch].rts_flow_en ? chan_ctl_in[ch].rts_flow_level :
				chan_ctl_in[ch].rts_gp_level;

			always_ff @(posedge clk_in or negedge rstn_in) begin
				if (!rstn_in) begin
					tx_reg <= hpms_pkg::TX_IDLE_PLAIN;
					rx_reg <= hpms_pkg::RX_IDLE_PLAIN;
					rts_n_reg <= hpms_pkg::RTS_RESET_LEVEL;
					cts_level_reg <= 1'b1;
					cts_hold_reg <= 1'b0;
				end else begin
					tx_reg <= tx_next;
					rx_reg <= rx_next;
					rts_n_reg <= rts_n_next;
					cts_level_reg <= cts_n_sync[ch];
					cts_hold_reg <= run && chan_ctl_in[ch].cts_flow_en &&
						cts_n_sync[ch];
				end
			end

			assign uart_tx_out[ch] = tx_reg;
			assign uart_rx_core_out[ch] = rx_reg;
			assign rts_n_vec[ch] = rts_n_reg;
			assign cts_level_out[ch] = cts_level_reg;
			assign cts_hold_tx_out[ch] = cts_hold_reg;
		end
	endgenerate

	assign request_to_send_ch0_n_out = rts_n_vec[0];
	assign request_to_send_ch1_n_out = rts_n_vec[1];

	// ==========================================================
	// modem lines shared with general-purpose pins
	logic modem_mode;
	logic [hpms_pkg::GPIO_W-1:0] gpio_out_reg;
	logic [hpms_pkg::GPIO_W-1:0] gpio_oe_reg;
	logic [hpms_pkg::GPIO_W-1:0] gpio_read_reg;
	logic [hpms_pkg::GPIO_W-1:0] gpio_oe_next;
	logic [hpms_pkg::GPIO_W-1:0] gpio_out_next;

	// modem mode drives only the terminal-ready pins
	assign modem_mode = pin_function_control_in[hpms_pkg::PIN_FUNC_MODEM_BIT];
	assign gpio_oe_next = !run ? '0 : modem_mode ? hpms_pkg::MODEM_OUT_MASK
		: pin_direction_control_in;
	assign gpio_out_next = modem_mode ? modem_out_level_in
		: gpio_sw_level_in;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			gpio_out_reg <= '0;
			gpio_oe_reg <= '0;
			gpio_read_reg <= '0;
		end else begin
			gpio_out_reg <= gpio_out_next;
			gpio_oe_reg <= gpio_oe_next;
			gpio_read_reg <= gpio_sync;
		end
	end
	assign gpio_out = gpio_out_reg;
	assign gpio_oe_out = gpio_oe_reg;
	assign gpio_read_out = gpio_read_reg;

endmodule : hpms_host_port_strap

// File: tb/hpms_host_port_strap_assertions.sv
`timescale 1ns/1ps
// ==========================================================
// port checker: straps, idle levels, request-to-send, pins
module hpms_host_port_strap_assertions (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic addr0_or_chip_select_n_in,
	input wire logic infrared_strap_n_in,
	input wire logic half_duplex_strap_n_in,
	input wire logic irq_request_in,
	input wire hpms_pkg::hpms_chan_ctl_t [hpms_pkg::CHANNELS-1:0] chan_ctl_in,
	input wire logic [hpms_pkg::GPIO_W-1:0] pin_function_control_in,
	input wire logic [hpms_pkg::GPIO_W-1:0] pin_direction_control_in,
	input wire hpms_pkg::hpms_mode_t mode_out,
	input wire logic strap_valid_out,
	input wire logic chip_selected_out,
	input wire logic irq_n_out,
	input wire logic irq_oe_out,
	input wire logic [hpms_pkg::CHANNELS-1:0] uart_tx_out,
	input wire logic request_to_send_ch0_n_out,
	input wire logic [hpms_pkg::GPIO_W-1:0] gpio_oe_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rstn_in);

	// ==========================================================
	// sequences
	// two quiet edges while the strap synchronisers fill
	sequence settle_s;
		!strap_valid_out ##1 !strap_valid_out;
	endsequence
	// select pin high long enough to pass the synchroniser
	sequence cs_high_s;
		addr0_or_chip_select_n_in [*4];
	endsequence

	// ==========================================================
	// properties
	tx_idle_a: assert property (
		!strap_valid_out && infrared_strap_n_in |-> uart_tx_out == 2'h3)
		else $error("transmit not idle before capture");
	strap_settle_a: assert property (
		$rose(rstn_in) |-> settle_s ##[1:3] strap_valid_out)
		else $error("strap capture not on time");
	strap_capture_a: assert property (
		$rose(strap_valid_out) |-> mode_out.infrared == !infrared_strap_n_in
		&& mode_out.auto_dir == !half_duplex_strap_n_in)
		else $error("captured mode differs from straps");
	strap_hold_a: assert property (
		strap_valid_out && $past(strap_valid_out) |->
		$stable(mode_out.infrared) && $stable(mode_out.auto_dir))
		else $error("latched mode changed");
	irq_drive_a: assert property (
		$past(rstn_in) |-> irq_oe_out == ($past(strap_valid_out)
		&& $past(irq_request_in)) && !irq_n_out)
		else $error("interrupt drive wrong");
	rts_dir_a: assert property (
		$past(strap_valid_out) && $past(mode_out.auto_dir) |->
		request_to_send_ch0_n_out == (!$past(chan_ctl_in[0].tx_busy)
		^ $past(chan_ctl_in[0].dir_invert)))
		else $error("direction level wrong");
	rts_flow_a: assert property (
		$past(strap_valid_out) && !$past(mode_out.auto_dir)
		&& !$past(chan_ctl_in[0].dir_enable) |-> request_to_send_ch0_n_out ==
		($past(chan_ctl_in[0].rts_flow_en) ? $past(chan_ctl_in[0].rts_flow_level)
		: $past(chan_ctl_in[0].rts_gp_level)))
		else $error("request-to-send source wrong");
	cs_quiet_a: assert property (
		cs_high_s |-> !chip_selected_out)
		else $error("selected with select pin high");
	gpio_dir_a: assert property (
		$past(strap_valid_out) |-> gpio_oe_out ==
		($past(pin_function_control_in[hpms_pkg::PIN_FUNC_MODEM_BIT])
		? hpms_pkg::MODEM_OUT_MASK : $past(pin_direction_control_in)))
		else $error("pin direction wrong");
endmodule : hpms_host_port_strap_assertions

bind hpms_host_port_strap hpms_host_port_strap_assertions chk (
	.clk_in(clk_in), .rstn_in(rstn_in),
	.addr0_or_chip_select_n_in(addr0_or_chip_select_n_in),
	.infrared_strap_n_in(infrared_strap_n_in),
	.half_duplex_strap_n_in(half_duplex_strap_n_in),
	.irq_request_in(irq_request_in), .chan_ctl_in(chan_ctl_in),
	.pin_function_control_in(pin_function_control_in),
	.pin_direction_control_in(pin_direction_control_in),
	.mode_out(mode_out), .strap_valid_out(strap_valid_out),
	.chip_selected_out(chip_selected_out), .irq_n_out(irq_n_out),
	.irq_oe_out(irq_oe_out), .uart_tx_out(uart_tx_out),
	.request_to_send_ch0_n_out(request_to_send_ch0_n_out),
	.gpio_oe_out(gpio_oe_out)
);

// File: tb/hpms_host_model.sv
`timescale 1ns/1ps
// ==========================================================
// host master: serial clock only runs inside a frame
module hpms_host_model (
	input wire logic two_wire_in,
	input wire logic [1:0] addr_level_in,
	output logic host_clk_out,
	output logic cs_n_out,
	output logic si_out
);
	logic busy = 1'b0;

	initial begin
		host_clk_out = 1'b0;
		cs_n_out = 1'b1;
		si_out = 1'b0;
	end

	// at rest the pins carry idle levels or the address straps
	always @(two_wire_in or addr_level_in or busy) begin
		if (!busy) begin
			host_clk_out = two_wire_in;
			cs_n_out = two_wire_in ? addr_level_in[0] : 1'b1;
			if (two_wire_in) si_out = addr_level_in[1];
		end
	end

	// msb first; data moves after the falling edge only
	task automatic send(input logic [7:0] b, input int n);
		busy = 1'b1;
		cs_n_out = 1'b0;
		for (int i = 7; i > 7 - n; i--) begin
			si_out = b[i];
			#6 host_clk_out = 1'b1;
			#6 host_clk_out = 1'b0;
		end
		#6 cs_n_out = 1'b1;
		// released data flips so a stale bit never looks valid
		si_out = ~si_out;
		busy = 1'b0;
	endtask : send

	// select held with the clock parked, so no bit moves
	task automatic hold_select(input int ns);
		busy = 1'b1;
		cs_n_out = 1'b0;
		#(ns) cs_n_out = 1'b1;
		busy = 1'b0;
	endtask : hold_select
endmodule : hpms_host_model

// File: tb/hpms_host_port_strap_test.sv
`timescale 1ns/1ps
module hpms_host_port_strap_test;
	logic clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic host_clk, addr0_or_chip_select_n_n, addr1_or_serial_in;
	logic port_select = 1'b0;
	logic ir_strap_n = 1'b1;
	logic hd_strap_n = 1'b1;
	logic irq_req = 1'b0;
	logic [1:0] lvl = 2'h3;
	logic [1:0] rx_pin = 2'h3;
	logic [1:0] cts_pin = 2'h3;
	logic [7:0] gp_pin = 8'h00, pfc = 8'h00, pdc = 8'h00;
	logic [7:0] gsw = 8'h00, mol = 8'h00;
	hpms_pkg::hpms_chan_ctl_t [1:0] ctl = '0;
	hpms_pkg::hpms_mode_t mode;
	logic sv, csel, hvalid, irq_n, irq_oe;
	logic [6:0] addr;
	logic [7:0] hbyte, gpo, gpoe, gprd;
	logic [1:0] tx, rxc, cts_lvl, cts_hold;
	wire logic [1:0] rts;
	int err_total = 0;
	int comparisons = 0;
	logic [7:0] exp_q[$];

	hpms_host_port_strap dut (
		.clk_in(clk_in), .rstn_in(rstn_in), .host_clk_in(host_clk),
		.port_select_in(port_select), .addr0_or_chip_select_n_in(addr0_or_chip_select_n_n),
		.addr1_or_serial_in_in(addr1_or_serial_in), .infrared_strap_n_in(ir_strap_n),
		.half_duplex_strap_n_in(hd_strap_n), .irq_request_in(irq_req),
		.chan_ctl_in(ctl), .uart_rx_pin_in(rx_pin),
		.clear_to_send_ch0_n_in(cts_pin[0]),
		.clear_to_send_ch1_n_in(cts_pin[1]),
		.gpio_pin_in(gp_pin), .pin_function_control_in(pfc),
		.pin_direction_control_in(pdc), .gpio_sw_level_in(gsw),
		.modem_out_level_in(mol), .mode_out(mode), .strap_valid_out(sv),
		.bus_address_out(addr), .chip_selected_out(csel),
		.host_byte_out(hbyte), .host_byte_valid_out(hvalid),
		.irq_n_out(irq_n), .irq_oe_out(irq_oe), .uart_tx_out(tx),
		.uart_rx_core_out(rxc), .request_to_send_ch0_n_out(rts[0]),
		.request_to_send_ch1_n_out(rts[1]), .cts_level_out(cts_lvl),
		.cts_hold_tx_out(cts_hold), .gpio_out(gpo), .gpio_oe_out(gpoe),
		.gpio_read_out(gprd)
	);

	hpms_host_model host (
		.two_wire_in(port_select), .addr_level_in(lvl),
		.host_clk_out(host_clk), .cs_n_out(addr0_or_chip_select_n_n), .si_out(addr1_or_serial_in)
	);

	// ==========================================================
	// clock and shared tasks
	initial begin
		forever #50 clk_in = ~clk_in;
	end

	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : tick

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : summarize

	// straps settle before reset so capture sees steady pins
	task automatic do_reset(input logic ir, input logic hd);
		ir_strap_n = ir;
		hd_strap_n = hd;
		rstn_in = 1'b0;
		for (int i = 0; i < 4; i++) begin
			rx_pin = 2'(i);
			tick(1);
			check({4'h0, tx, rxc}, 8'h0F);
		end
		rstn_in = 1'b1;
		for (int i = 0; i < 20 && sv !== 1'b1; i++) tick(1);
		tick(2);
		check({7'h00, sv}, 8'h01);
	endtask : do_reset

	function automatic logic exp_rts(input hpms_pkg::hpms_chan_ctl_t c,
		input logic ad);
		if (ad || c.dir_enable) return !c.tx_busy ^ c.dir_invert;
		return c.rts_flow_en ? c.rts_flow_level : c.rts_gp_level;
	endfunction : exp_rts

	task automatic pins_check(input logic ad, input logic ir);
		for (int i = 0; i < 4; i++) begin
			ctl = 18'($urandom);
			tick(2);
			for (int c = 0; c < 2; c++) begin
				check({7'h00, tx[c]},
					{7'h00, ir ? ctl[c].tx_ir : ctl[c].tx_data});
				check({7'h00, rts[c]}, {7'h00, exp_rts(ctl[c], ad)});
			end
		end
	endtask : pins_check

	// ==========================================================
	// byte monitor: each pulse takes the oldest expected byte
	always @(posedge clk_in) begin
		if (hvalid === 1'b1) begin
			if (exp_q.size() == 0) check({7'h00, hvalid}, 8'h00);
			else check(hbyte, exp_q.pop_front());
		end
	end

	// watchdog sized well past the hundred-odd cycles the tests need
	initial begin
		#500000;
		err_total++;
		summarize();
	end

	// ==========================================================
	// tests
	initial begin
		logic [7:0] b;
		void'($urandom(30186));
		tick(1);
		do_reset(1'b1, 1'b1);
		check({5'h00, mode}, 8'h00);
		pins_check(1'b0, 1'b0);
		for (int i = 0; i < 4; i++) begin
			b = 8'($urandom);
			exp_q.push_back(b);
			host.send(b, 8);
			tick(6);
		end
		// a short frame must be dropped when select rises
		host.send(8'hA5, 5);
		tick(6);
		// a long select must reach the selected flag through the sync
		fork
			host.hold_select(500);
			begin
				tick(4);
				check({7'h00, csel}, 8'h01);
			end
		join
		ir_strap_n = 1'b0;
		hd_strap_n = 1'b0;
		tick(6);
		check({5'h00, mode}, 8'h00);
		$display("test four-wire link finished");
		do_reset(1'b0, 1'b0);
		check({5'h00, mode}, 8'h03);
		pins_check(1'b1, 1'b1);
		$display("test infrared and direction finished");
		port_select = 1'b1;
		for (int i = 0; i < 4; i++) begin
			lvl = 2'(i);
			do_reset(1'b1, 1'b1);
			check({1'b0, addr}, {1'b0, hpms_pkg::BUS_ADDR_BASE
				| {4'h0, ~lvl[1], 1'b0, ~lvl[0]}});
			check({5'h00, mode}, 8'h04);
			check({7'h00, csel}, 8'h00);
		end
		$display("test two-wire address finished");
		for (int i = 0; i < 4; i++) begin
			cts_pin = 2'($urandom);
			rx_pin = 2'($urandom);
			gp_pin = 8'($urandom);
			pfc = 8'($urandom);
			pdc = 8'($urandom);
			gsw = 8'($urandom);
			mol = 8'($urandom);
			irq_req = 1'(i);
			tick(4);
			check({6'h00, cts_lvl}, {6'h00, cts_pin});
			check({6'h00, cts_hold}, {6'h00, cts_pin
				& {ctl[1].cts_flow_en, ctl[0].cts_flow_en}});
			check(gprd, gp_pin);
			check(gpoe, pfc[hpms_pkg::PIN_FUNC_MODEM_BIT]
				? hpms_pkg::MODEM_OUT_MASK : pdc);
			check(gpo, pfc[hpms_pkg::PIN_FUNC_MODEM_BIT]
				? mol : gsw);
			check({6'h00, rxc}, {6'h00, rx_pin});
			check({6'h00, irq_oe, irq_n}, {6'h00, irq_req, 1'b0});
		end
		$display("test pins and interrupt finished");
		check(8'(exp_q.size()), 8'h00);
		summarize();
	end
endmodule : hpms_host_port_strap_test
